// file: rtl/fws_host.sv
/*
 * Host-side controller that drives an asynchronous parallel flash through its
 * pins and runs the toggle-bit status procedure, reported through APB registers.
 * Assumes flash inputs are synchronous to ref_clk and the data bus wire is
 * resolved outside from dqOe; ready_busy_n is pulled up outside.
 */
`timescale 1ns/1ps

module fws_host
    import fws_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // flash pins
    output fws_pkg::fws_flash_out_t flashOut,
    input wire logic [15:0] flashDqIn,
    input wire logic readyBusyN
);
    import fws_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0000,
        S_WR = 4'b0001,
        S_RD1 = 4'b0010,
        S_RD2 = 4'b0011,
        S_RD3 = 4'b0100,
        S_RD4 = 4'b0101,
        S_RST = 4'b0110,
        S_PRE = 4'b0111,
        S_POST = 4'b1000
    } fws_state_t;

    typedef enum logic [1:0] {
        C_IDLE = 2'b00,
        C_ACT = 2'b01,
        C_HOLD = 2'b10
    } fws_cyc_t;

    fws_state_t state_q, state_d;
    fws_cyc_t cyc_q;
    logic [4:0] cnt_q;
    logic [18:0] addr_q;
    logic [15:0] wdata_q;
    logic [15:0] rdata_q;
    logic done_q, fail_q, reject_q, window_q, toggling_q, firstTog_q, guard_q;
    logic csN_q, oeN_q, weN_q, dqOe_q;
    logic [15:0] dqOut_q;

    // apb decode
    wire apbWr = psel && penable && pwrite;
    wire selCtrl = (paddr == FWS_OFF_CTRL);
    wire selAddr = (paddr == FWS_OFF_ADDR);
    wire selWdata = (paddr == FWS_OFF_WDATA);
    wire selStatus = (paddr == FWS_OFF_STATUS);
    wire selRdata = (paddr == FWS_OFF_RDATA);
    wire mapped = selCtrl || selAddr || selWdata || selStatus || selRdata;
    wire busy = (state_q != S_IDLE);
    // commands while busy are dropped; software watches the busy bit
    wire cmdGo = apbWr && selCtrl && !busy;
    wire [31:0] statusWord = {25'h0000000, readyBusyN, toggling_q, window_q,
                              reject_q, fail_q, done_q, busy};

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = selStatus ? statusWord
                  : selAddr ? {13'h0000, addr_q}
                  : selWdata ? {16'h0000, wdata_q}
                  : selRdata ? {16'h0000, rdata_q}
                  : 32'h00000000;

    // bus cycle engine
    wire cycWrite = (state_q == S_WR) || (state_q == S_RST);
    wire cycStart = busy && (cyc_q == C_IDLE);
    wire cycDone = (cyc_q == C_HOLD);
    wire [15:0] cycData = (state_q == S_RST) ? FWS_RESET_CMD : wdata_q;
    wire lastAct = (cyc_q == C_ACT) && (cnt_q == 5'h01);

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cyc_q <= C_IDLE;
            cnt_q <= 5'h00;
        end
        else if (cycStart)
        begin
            cyc_q <= C_ACT;
            cnt_q <= cycWrite ? FWS_WP_CYC : FWS_ACC_CYC;
        end
        else if (lastAct)
            cyc_q <= C_HOLD;
        else if (cyc_q == C_ACT)
            cnt_q <= cnt_q - 5'h01;
        else if (cycDone)
            cyc_q <= C_IDLE;
    end

    // pin drive; write strobe rises one cycle before data and select let go
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            csN_q <= 1'b1;
            oeN_q <= 1'b1;
            weN_q <= 1'b1;
            dqOe_q <= 1'b0;
            dqOut_q <= 16'h0000;
            rdata_q <= 16'h0000;
        end
        else if (cycStart)
        begin
            csN_q <= 1'b0;
            oeN_q <= cycWrite;
            weN_q <= !cycWrite;
            dqOe_q <= cycWrite;
            dqOut_q <= cycData;
        end
        else if (lastAct)
        begin
            oeN_q <= 1'b1;
            weN_q <= 1'b1;
            csN_q <= cycWrite ? 1'b0 : 1'b1;
            if (!cycWrite)
                rdata_q <= flashDqIn;
        end
        else if (cycDone)
        begin
            csN_q <= 1'b1;
            dqOe_q <= 1'b0;
        end
    end

    // every status read uses the programmed address
    assign flashOut = '{chipSelectN: csN_q, outputStrobeN: oeN_q, writeStrobeN: weN_q,
                        dqOe: dqOe_q, addr: addr_q, dqOut: dqOut_q};

    wire togDiff = rdata_q[FWS_DQ_TOGGLE] != firstTog_q;
    wire tmoHigh = rdata_q[FWS_DQ_TIMEOUT];

    // status procedure
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            S_IDLE:
                if (cmdGo && pwdata[FWS_CTRL_WRITE])
                    state_d = S_WR;
                else if (cmdGo && pwdata[FWS_CTRL_POLL])
                    state_d = S_RD1;
                else if (cmdGo && pwdata[FWS_CTRL_RESET])
                    state_d = S_RST;
                else if (cmdGo && pwdata[FWS_CTRL_GUARD])
                    state_d = S_PRE;
            S_WR:
                if (cycDone)
                    state_d = guard_q ? S_POST : S_IDLE;
            S_PRE:
                if (cycDone)
                    state_d = S_WR;
            S_POST:
                if (cycDone)
                    state_d = S_IDLE;
            S_RD1:
                if (cycDone)
                    state_d = S_RD2;
            S_RD2:
                if (cycDone)
                begin
                    if (!togDiff)
                        state_d = S_IDLE;
                    else if (tmoHigh)
                        state_d = S_RD3;
                    else
                        state_d = S_RD1;
                end
            S_RD3:
                if (cycDone)
                    state_d = S_RD4;
            S_RD4:
                if (cycDone)
                    state_d = togDiff ? S_RST : S_IDLE;
            S_RST:
                if (cycDone)
                    state_d = S_IDLE;
            default:
                state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            state_q <= S_IDLE;
        else
            state_q <= state_d;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            addr_q <= FWS_ADDR_RST;
            wdata_q <= FWS_WDATA_RST;
        end
        else if (apbWr && !busy)
        begin
            if (selAddr)
                addr_q <= pwdata[18:0];
            else if (selWdata)
                wdata_q <= pwdata[15:0];
        end
    end

    // result flags; a new command clears done, fail and reject
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            done_q <= 1'b0;
            fail_q <= 1'b0;
            reject_q <= 1'b0;
            window_q <= 1'b0;
            toggling_q <= 1'b0;
            firstTog_q <= 1'b0;
            guard_q <= 1'b0;
        end
        else if (state_q == S_IDLE && state_d != S_IDLE)
        begin
            done_q <= 1'b0;
            fail_q <= 1'b0;
            reject_q <= 1'b0;
            guard_q <= (state_d == S_PRE);
        end
        else if (cycDone)
        begin
            if (state_q == S_RD1 || state_q == S_RD3)
                firstTog_q <= rdata_q[FWS_DQ_TOGGLE];
            if (!cycWrite)
                window_q <= rdata_q[FWS_DQ_WINDOW];
            if (state_q == S_RD2 || state_q == S_RD4)
                toggling_q <= togDiff;
            // high after the added command: it may not have been taken
            if (state_q == S_POST && rdata_q[FWS_DQ_WINDOW])
                reject_q <= 1'b1;
            if (state_q == S_RD4 && togDiff)
                fail_q <= 1'b1;
            if (state_d == S_IDLE)
                done_q <= 1'b1;
        end
    end

    sequence rdPairEnds;
        state_q == S_RD2 && cycDone;
    endsequence

    chk_two_reads_done: assert property (@(posedge ref_clk) disable iff (rst)
        rdPairEnds and !togDiff |=> state_q == S_IDLE && done_q && !toggling_q)
        else $error("equal toggle pair did not finish the poll");

    chk_timeout_recheck: assert property (@(posedge ref_clk) disable iff (rst)
        rdPairEnds and togDiff && tmoHigh |=> state_q == S_RD3)
        else $error("timeout bit high without toggle recheck");

    chk_restart_pair: assert property (@(posedge ref_clk) disable iff (rst)
        rdPairEnds and togDiff && !tmoHigh |=> state_q == S_RD1 ##1 state_q == S_RD1)
        else $error("poll did not restart from the double read");

    chk_fail_reset: assert property (@(posedge ref_clk) disable iff (rst)
        state_q == S_RD4 && cycDone && togDiff |=> state_q == S_RST ##1 !weN_q)
        else $error("failed recheck not followed by reset write");

    chk_reset_code: assert property (@(posedge ref_clk) disable iff (rst)
        state_q == S_RST && cyc_q == C_ACT |-> dqOe_q && dqOut_q == 16'h00F0 && !weN_q)
        else $error("reset write does not carry F0");

    chk_guard_flags: assert property (@(posedge ref_clk) disable iff (rst)
        state_q == S_POST && cycDone && rdata_q[FWS_DQ_WINDOW] |=> reject_q && !busy)
        else $error("window high after add not flagged");

    chk_poll_addr: assert property (@(posedge ref_clk) disable iff (rst)
        !oeN_q |-> flashOut.addr == addr_q && !csN_q && !dqOe_q)
        else $error("status read without the programmed address");

    chk_we_pulse: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(weN_q) |-> !weN_q[*7] ##1 (weN_q && !csN_q && dqOe_q))
        else $error("write strobe width or release order wrong");

endmodule : fws_host

// file: rtl/fws_pkg.sv
/*
 * Shared constants and types for the flash write-status host controller:
 * register map, control/status field positions, reset values, bus-cycle timing.
 * Assumes a 125 MHz single clock and an APB slave with 32-bit data.
 */
package fws_pkg;

    // register byte offsets
    localparam logic [7:0] FWS_OFF_CTRL = 8'h00;
    localparam logic [7:0] FWS_OFF_ADDR = 8'h04;
    localparam logic [7:0] FWS_OFF_WDATA = 8'h08;
    localparam logic [7:0] FWS_OFF_STATUS = 8'h0C;
    localparam logic [7:0] FWS_OFF_RDATA = 8'h10;

    // control bits (write 1 to launch; one command at a time)
    localparam int FWS_CTRL_WRITE = 0;
    localparam int FWS_CTRL_POLL = 1;
    localparam int FWS_CTRL_RESET = 2;
    localparam int FWS_CTRL_GUARD = 3;

    // status bits
    localparam int FWS_ST_BUSY = 0;
    localparam int FWS_ST_DONE = 1;
    localparam int FWS_ST_FAIL = 2;
    localparam int FWS_ST_REJECT = 3;
    localparam int FWS_ST_WINDOW = 4;
    localparam int FWS_ST_TOGGLING = 5;
    localparam int FWS_ST_READY = 6;

    // status bit positions on the flash data bus
    localparam int FWS_DQ_TOGGLE = 6;
    localparam int FWS_DQ_TIMEOUT = 5;
    localparam int FWS_DQ_WINDOW = 3;

    // reset values
    localparam logic [18:0] FWS_ADDR_RST = 19'h00000;
    localparam logic [15:0] FWS_WDATA_RST = 16'h0000;
    localparam logic [15:0] FWS_RESET_CMD = 16'h00F0;

    // bus-cycle timing
    localparam int FWS_CLK_MHZ = 125;
    localparam int FWS_T_ACC_NS = 120;
    localparam int FWS_T_WP_NS = 50;
    localparam logic [4:0] FWS_ACC_CYC = 5'((FWS_T_ACC_NS * FWS_CLK_MHZ + 999) / 1000);
    localparam logic [4:0] FWS_WP_CYC = 5'((FWS_T_WP_NS * FWS_CLK_MHZ + 999) / 1000);

    // pins driven toward the flash
    typedef struct packed {
        logic chipSelectN;
        logic outputStrobeN;
        logic writeStrobeN;
        logic dqOe;
        logic [18:0] addr;
        logic [15:0] dqOut;
    } fws_flash_out_t;

endpackage : fws_pkg

// file: verif/fws_flash_model.sv
/*
 * Behavioural flash status side for the fws_host bench: toggle, timeout and
 * window bits, ready/busy drive. Assumes host pins synchronous to ref_clk.
 */
`timescale 1ns/1ps
module fws_flash_model #(
    parameter logic [15:0] ARRAY_WORD = 16'h1234
)
(
    // host side
    input wire logic ref_clk,
    input wire fws_pkg::fws_flash_out_t pins,
    // scenario knobs
    input wire logic [7:0] opLen,
    input wire logic failMode,
    // device side
    output logic [15:0] dq,
    output logic rbOe,
    output logic [15:0] lastWr,
    output logic [18:0] lastAd
);
    import fws_pkg::*;
    logic busyQ = 1'b0;
    logic failQ = 1'b0;
    logic togQ = 1'b0;
    logic winQ = 1'b0;
    logic ersQ = 1'b0;
    logic rdQ = 1'b0;
    logic wrQ = 1'b0;
    logic [7:0] nRd = 8'h00;
    logic [15:0] lastQ = 16'h0000;
    wire statusOn = busyQ | failQ;
    // every address counts as inside the erased sector
    wire [15:0] word = statusOn ? {8'h00, !ersQ & !ARRAY_WORD[7], togQ, failQ, 1'b0, winQ,
        ersQ & togQ, 2'h0} : ARRAY_WORD;
    wire rdEnd = rdQ & pins.outputStrobeN;
    wire wrEnd = wrQ & pins.writeStrobeN;
    // released bus shows a moving pattern so a late sample cannot pass
    assign dq = (!pins.chipSelectN && !pins.outputStrobeN) ? word
        : pins.dqOe ? pins.dqOut : ~lastQ;
    assign rbOe = statusOn;

    always @(posedge ref_clk)
    begin
        lastQ <= dq;
        rdQ <= !pins.chipSelectN && !pins.outputStrobeN;
        wrQ <= !pins.chipSelectN && !pins.writeStrobeN;
        if (rdEnd && statusOn)
        begin
            togQ <= !togQ;
            nRd <= nRd + 8'h01;
            if (busyQ && nRd == opLen - 8'h01)
            begin
                // after opLen status reads the operation ends: failQ takes failMode, back to array unless it is set
                busyQ <= 1'b0;
                failQ <= failMode;
                winQ <= 1'b0;
                ersQ <= 1'b0;
            end
        end
        // erase under way with its window closed: only suspend is heard
        if (wrEnd && !(busyQ && winQ && pins.dqOut != 16'h00B0))
        begin
            lastWr <= pins.dqOut;
            lastAd <= pins.addr;
            nRd <= 8'h00;
            case (pins.dqOut)
                16'h00F0: {busyQ, failQ, winQ, ersQ} <= 4'h0;
                16'h00A0: busyQ <= 1'b1;
                16'h0030: {busyQ, winQ, ersQ} <= 3'h7;
                16'h00B0: if (ersQ) busyQ <= 1'b0;
                default: ;
            endcase
        end
    end
endmodule : fws_flash_model

// file: verif/tb_fws_host.sv
/*
 * Self-checking bench for fws_host over APB against a behavioural flash.
 * Assumes fws_flash_model and an external pull-up on ready/busy.
 */
`timescale 1ns/1ps
module tb_fws_host;
    import fws_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    fws_flash_out_t flashOut;
    logic [15:0] flashDq;
    logic rbOe;
    logic [15:0] lastWr;
    logic [18:0] lastAd;
    logic [7:0] opLen = 8'h05;
    logic failMode = 1'b0;
    logic [31:0] rd;
    int n_fail = 0;
    int checked = 0;
    // open drain with pull-up
    wire readyBusyN = !rbOe;

    always #4 ref_clk = ~ref_clk;

    fws_host dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flashOut(flashOut), .flashDqIn(flashDq), .readyBusyN(readyBusyN));
    fws_flash_model flash (.ref_clk(ref_clk), .pins(flashOut), .opLen(opLen),
        .failMode(failMode), .dq(flashDq), .rbOe(rbOe), .lastWr(lastWr), .lastAd(lastAd));

    task automatic results;
        $display("checks=%0d mismatches=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // no wait-state count assumed; only the watchdog ends a stuck access
        do
        begin
            @(posedge ref_clk);
        end
        while (pready !== 1'b1);
        rd = pslverr === 1'b1 ? 32'hFFFFFFFF : prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic cmd(input int b);
        int n;
        n = 0;
        apb(1'b1, FWS_OFF_CTRL, 32'h00000001 << b);
        do
        begin
            apb(1'b0, FWS_OFF_STATUS, 32'h00000000);
            n++;
        end
        while (rd[FWS_ST_BUSY] !== 1'b0 && n < 400);
        if (n >= 400)
            n_fail++;
    endtask : cmd

    task automatic sc_reset;
        chk({28'h0000000, flashOut.chipSelectN, flashOut.outputStrobeN,
            flashOut.writeStrobeN, flashOut.dqOe}, 32'h0000000E);
        apb(1'b0, FWS_OFF_STATUS, 32'h00000000);
        chk(rd, 32'h00000040);
        apb(1'b0, 8'h14, 32'h00000000);
        chk(rd, 32'hFFFFFFFF);
        apb(1'b1, FWS_OFF_ADDR, 32'hFFFFFFFF);
        apb(1'b0, FWS_OFF_ADDR, 32'h00000000);
        chk(rd, 32'h0007FFFF);
        apb(1'b1, FWS_OFF_WDATA, 32'hFFFFFFFF);
        apb(1'b0, FWS_OFF_WDATA, 32'h00000000);
        chk(rd, 32'h0000FFFF);
    endtask : sc_reset

    task automatic sc_idle_poll;
        cmd(FWS_CTRL_POLL);
        chk(rd, 32'h00000042);
        apb(1'b0, FWS_OFF_RDATA, 32'h00000000);
        chk(rd, 32'h00001234);
    endtask : sc_idle_poll

    task automatic sc_program;
        apb(1'b1, FWS_OFF_ADDR, 32'h0002AAAA);
        apb(1'b1, FWS_OFF_WDATA, 32'h000000A0);
        cmd(FWS_CTRL_WRITE);
        chk({16'h0000, lastWr}, 32'h000000A0);
        chk({13'h0000, lastAd}, 32'h0002AAAA);
        chk(rd & 32'h00000040, 32'h00000000);
        // address write lands while busy and must be dropped
        apb(1'b1, FWS_OFF_CTRL, 32'h00000002);
        apb(1'b1, FWS_OFF_ADDR, 32'h00000000);
        cmd(FWS_CTRL_POLL);
        chk(rd, 32'h00000042);
        apb(1'b0, FWS_OFF_ADDR, 32'h00000000);
        chk(rd, 32'h0002AAAA);
    endtask : sc_program

    task automatic sc_fail;
        opLen <= 8'h03;
        failMode <= 1'b1;
        cmd(FWS_CTRL_WRITE);
        cmd(FWS_CTRL_POLL);
        chk(rd & 32'h00000047, 32'h00000046);
        chk({16'h0000, lastWr}, 32'h000000F0);
        failMode <= 1'b0;
        opLen <= 8'h05;
    endtask : sc_fail

    task automatic sc_guard(input logic [15:0] w, input logic [31:0] exp);
        apb(1'b1, FWS_OFF_WDATA, {16'h0000, w});
        cmd(FWS_CTRL_GUARD);
        chk(rd & 32'h00000058, exp);
        cmd(FWS_CTRL_POLL);
        chk(rd, 32'h00000042);
    endtask : sc_guard

    // erase running with its window closed: the added program must be ignored
    task automatic sc_closed;
        apb(1'b1, FWS_OFF_WDATA, 32'h00000030);
        cmd(FWS_CTRL_WRITE);
        apb(1'b1, FWS_OFF_WDATA, 32'h000000A0);
        cmd(FWS_CTRL_GUARD);
        chk(rd & 32'h00000058, 32'h00000018);
        chk({16'h0000, lastWr}, 32'h00000030);
        cmd(FWS_CTRL_POLL);
        chk(rd, 32'h00000042);
    endtask : sc_closed

    initial
    begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        sc_reset();
        sc_idle_poll();
        sc_program();
        sc_fail();
        sc_guard(16'h0030, 32'h00000018);
        sc_closed();
        sc_guard(16'h00A0, 32'h00000000);
        results();
    end

    initial
    begin
        #300000;
        n_fail++;
        results();
    end
endmodule : tb_fws_host
